// >>> src/wake_pkg.sv
package wake_pkg;
  localparam int CLK_HZ = 40000000;
  // Times in microseconds as defaults
  localparam int T_BUS_US = 30;
  localparam int T_MON_US = 300;
  localparam int T_IGN_DEB_US = 150;
  localparam int T_STARTUP_US = 4000;
  localparam int T_RESET_US = 4000;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam int BUS_WAKE_CYC = T_BUS_US * CYC_PER_US;
  localparam int MON_CYC = T_MON_US * CYC_PER_US;
  localparam int IGN_DEB_CYC = T_IGN_DEB_US * CYC_PER_US;
  localparam int STARTUP_CYC = T_STARTUP_US * CYC_PER_US;
  localparam int RESET_CYC = T_RESET_US * CYC_PER_US;
  localparam int CNT_W = 24;
  localparam int SPI_BITS = 16;
  localparam int CFG_LIN_EN = 12;
  localparam int CFG_SLEEP = 11;
  localparam int CFG_WDOG_DIS = 9;
  localparam int CFG_SRC_CTRL = 8;
  localparam int ST_SRC_HI = 15;
  localparam int ST_SRC_LO = 14;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_IGN = 2'h2;
  localparam logic [1:0] SRC_BUS = 2'h3;
  localparam logic [1:0] SRC_OTHER = 2'h1;
  typedef enum logic [2:0] {
    M_SLEEP, M_POWERUP, M_STARTUP, M_ACTIVE
  } mode_e;
  typedef enum logic [1:0] {
    B_IDLE, B_LOW, B_STUCK
  } bus_e;
endpackage

// >>> src/spi_word_if.sv
`timescale 1ns/1ps
interface spi_word_if;
  logic [15:0] status_word;
  logic [15:0] cfg_word;
  logic cfg_strobe;
  logic read_strobe;
  logic enable;
  modport shifter (input status_word, input enable, output cfg_word,
    output cfg_strobe, output read_strobe);
  modport ctrl (output status_word, output enable, input cfg_word,
    input cfg_strobe, input read_strobe);
endinterface

// >>> src/spi_word_shifter.sv
`timescale 1ns/1ps
module spi_word_shifter
  import wake_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  spi_word_if.shifter port_w
);
  logic [1:0] sck_s, mosi_s;
  logic sck_d;
  logic sel_d;
  logic [15:0] shift;
  logic [4:0] count;
  logic [15:0] tx;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s <= 2'h0;
      mosi_s <= 2'h0;
      sck_d <= 1'b0;
      sel_d <= 1'b1;
    end else begin
      sck_s <= {sck_s[0], sck};
      mosi_s <= {mosi_s[0], mosi};
      sck_d <= sck_s[1];
      sel_d <= sel_n;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= 16'h0000;
      count <= 5'h00;
      tx <= 16'h0000;
      miso <= 1'b0;
      port_w.cfg_word <= 16'h0000;
      port_w.cfg_strobe <= 1'b0;
      port_w.read_strobe <= 1'b0;
    end else begin
      port_w.cfg_strobe <= 1'b0;
      port_w.read_strobe <= 1'b0;
      if (!port_w.enable) begin
        count <= 5'h00;
        miso <= 1'b0;
      end else if (sel_d && !sel_n) begin
        tx <= port_w.status_word;
        miso <= port_w.status_word[15];
        count <= 5'h00;
        port_w.read_strobe <= 1'b1;
      end else if (!sel_n && !sck_d && sck_s[1]) begin
        shift <= {shift[14:0], mosi_s[1]};
        count <= count + 5'h01;
      end else if (!sel_n && sck_d && !sck_s[1]) begin
        tx <= {tx[14:0], 1'b0};
        miso <= tx[14];
      end else if (!sel_d && sel_n) begin
        if (count == 5'(SPI_BITS)) begin
          port_w.cfg_word <= shift;
          port_w.cfg_strobe <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> src/wake_power_seq.sv
`timescale 1ns/1ps
module wake_power_seq
  import wake_pkg::*;
#(
  parameter int BUS_WAKE_N = BUS_WAKE_CYC,
  parameter int MON_N = MON_CYC,
  parameter int IGN_DEB_N = IGN_DEB_CYC,
  parameter int STARTUP_N = STARTUP_CYC,
  parameter int RESET_N = RESET_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_below_prewake,
  input wire logic bus_dominant,
  input wire logic ignition_wake_input,
  input wire logic supply_valid,
  input wire logic vs_undervoltage,
  input wire logic vs_below_min,
  input wire logic wdog_strap,
  input wire logic spi_select_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic scan_pulse_y,
  input wire logic switch_change,
  input wire logic [7:0] source_enable_x,
  input wire logic [7:0] source_irq_enable_x,
  output logic spi_miso,
  output logic interrupt_request_n,
  output logic mcu_reset_out_n,
  output logic regulator_en,
  output logic termination_en,
  output logic receiver_en,
  output logic transceiver_en,
  output logic switch_unit_en,
  output logic watchdog_en,
  output logic low_power,
  output logic wake_source_bit_hi,
  output logic wake_source_bit_lo
);
  spi_word_if port_w ();
  logic [2:0] s_prewake, s_dom, s_ign, s_uv, s_min, s_sel, s_scan, s_sw;
  logic [1:0] s_valid, s_strap;
  logic prewake, dom, ign, uv, vmin, sel_n, scan, valid, sw_chg;
  logic dom_q, ign_q;
  mode_e mode;
  bus_e bus_st;
  logic [CNT_W-1:0] bus_cnt, mon_cnt, ign_cnt, tim_cnt;
  logic [15:0] cfg;
  logic [1:0] src;
  logic bus_wake, bus_stuck_wake, ign_wake, ign_armed, mon_block;
  logic event_now, irq_pend, uv_q, wd_strap_q;

  function automatic logic [CNT_W-1:0] cnt_of(input int n);
    cnt_of = CNT_W'(n);
  endfunction

  // Pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_prewake <= 3'h0;
      s_dom <= 3'h0;
      s_ign <= 3'h0;
      s_uv <= 3'h0;
      s_min <= 3'h0;
      s_sel <= 3'h7;
      s_scan <= 3'h0;
      s_sw <= 3'h0;
      s_valid <= 2'h0;
      s_strap <= 2'h0;
    end else begin
      s_prewake <= {s_prewake[1:0], bus_below_prewake};
      s_dom <= {s_dom[1:0], bus_dominant};
      s_ign <= {s_ign[1:0], ignition_wake_input};
      s_uv <= {s_uv[1:0], vs_undervoltage};
      s_min <= {s_min[1:0], vs_below_min};
      s_sel <= {s_sel[1:0], spi_select_n};
      s_scan <= {s_scan[1:0], scan_pulse_y};
      s_sw <= {s_sw[1:0], switch_change};
      s_valid <= {s_valid[0], supply_valid};
      s_strap <= {s_strap[0], wdog_strap};
    end
  end
  assign prewake = s_prewake[1];
  assign dom = s_dom[1];
  assign ign = s_ign[1];
  assign uv = s_uv[1];
  assign vmin = s_min[1];
  assign sel_n = s_sel[1];
  assign scan = s_scan[1];
  assign sw_chg = s_sw[1];
  assign valid = s_valid[1];
  assign dom_q = s_dom[2];
  assign ign_q = s_ign[2];

  // Bus wake detector, used in sleep and low-power
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_st <= B_IDLE;
      bus_cnt <= '0;
      mon_cnt <= '0;
      bus_wake <= 1'b0;
      bus_stuck_wake <= 1'b0;
      receiver_en <= 1'b0;
      mon_block <= 1'b0;
    end else begin
      bus_wake <= 1'b0;
      bus_stuck_wake <= 1'b0;
      mon_block <= mon_block && prewake;
      if (!(mode == M_SLEEP || low_power) || cfg[CFG_LIN_EN]) begin
        bus_st <= B_IDLE;
        receiver_en <= 1'b0;
      end else begin
        case (bus_st)
          B_IDLE: begin
            bus_cnt <= '0;
            mon_cnt <= '0;
            if (prewake && !mon_block) begin
              bus_st <= B_LOW;
              receiver_en <= 1'b1;
            end
          end
          B_LOW: begin
            mon_cnt <= mon_cnt + 1'b1;
            if (dom) begin
              if (dom_q && bus_cnt < cnt_of(BUS_WAKE_N)) begin
                bus_cnt <= bus_cnt + 1'b1;
              end
            end else begin
              bus_cnt <= '0;
            end
            if (!dom && dom_q && bus_cnt >= cnt_of(BUS_WAKE_N)) begin
              bus_wake <= 1'b1;
              bus_st <= B_IDLE;
              receiver_en <= 1'b0;
            end else if (mon_cnt >= cnt_of(MON_N) - 1'b1) begin
              bus_st <= dom ? B_STUCK : B_IDLE;
              mon_block <= !dom;
              receiver_en <= 1'b0;
            end else if (!prewake && !dom) begin
              bus_st <= B_IDLE;
              receiver_en <= 1'b0;
            end
          end
          B_STUCK: begin
            if (!dom) begin
              bus_stuck_wake <= 1'b1;
              bus_st <= B_IDLE;
            end
          end
          default: bus_st <= B_IDLE;
        endcase
      end
    end
  end

  // Ignition debounce, re-armed after low for debounce time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ign_cnt <= '0;
      ign_wake <= 1'b0;
      ign_armed <= 1'b1;
    end else begin
      ign_wake <= 1'b0;
      if (ign != ign_q) begin
        ign_cnt <= '0;
      end else if (ign_cnt < cnt_of(IGN_DEB_N)) begin
        ign_cnt <= ign_cnt + 1'b1;
      end
      if (ign && ign_armed && ign_cnt == cnt_of(IGN_DEB_N) - 1'b1) begin
        ign_wake <= 1'b1;
        ign_armed <= 1'b0;
      end else if (!ign && ign_cnt == cnt_of(IGN_DEB_N) - 1'b1) begin
        ign_armed <= 1'b1;
      end
    end
  end

  // Strap captured during power-up, before reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_strap_q <= 1'b0;
    end else if (mode == M_POWERUP) begin
      wd_strap_q <= s_strap[1];
    end
  end

  // Mode sequencer and reset timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= M_POWERUP;
      tim_cnt <= '0;
      mcu_reset_out_n <= 1'b0;
      regulator_en <= 1'b1;
      termination_en <= 1'b0;
    end else begin
      case (mode)
        M_SLEEP: begin
          mcu_reset_out_n <= 1'b0;
          tim_cnt <= '0;
          if (bus_wake || bus_stuck_wake || ign_wake) begin
            regulator_en <= 1'b1;
            termination_en <= 1'b1;
            mode <= M_POWERUP;
          end
        end
        M_POWERUP: begin
          tim_cnt <= '0;
          if (valid) begin
            mode <= M_STARTUP;
          end
        end
        M_STARTUP: begin
          tim_cnt <= tim_cnt + 1'b1;
          if (tim_cnt >= cnt_of(termination_en ? STARTUP_N : RESET_N)
              - 1'b1) begin
            mcu_reset_out_n <= 1'b1;
            mode <= M_ACTIVE;
          end
        end
        M_ACTIVE: begin
          termination_en <= 1'b1;
          if (port_w.cfg_strobe && port_w.cfg_word[CFG_SLEEP]) begin
            mode <= M_SLEEP;
            regulator_en <= 1'b0;
            mcu_reset_out_n <= 1'b0;
            termination_en <= 1'b0;
          end
        end
        default: mode <= M_POWERUP;
      endcase
    end
  end

  // Configuration register, taken only when SPI is ready
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (mode != M_ACTIVE) begin
      cfg <= CFG_RESET;
    end else if (port_w.cfg_strobe) begin
      cfg <= port_w.cfg_word;
    end
  end
  assign port_w.enable = (mode == M_ACTIVE) && !uv;

  // Wake source record, cleared after first status read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src <= SRC_NONE;
    end else if (bus_wake || bus_stuck_wake) begin
      src <= SRC_BUS;
    end else if (ign_wake) begin
      src <= SRC_IGN;
    end else if ((sw_chg && low_power) || (uv && !uv_q && mode == M_ACTIVE)) begin
      src <= SRC_OTHER;
    end else if (port_w.read_strobe) begin
      src <= SRC_NONE;
    end
  end
  assign port_w.status_word = {src, 1'b0, cfg[CFG_LIN_EN], 12'h000};

  // Events and interrupt line
  assign event_now = bus_wake || bus_stuck_wake || ign_wake
    || (sw_chg && low_power && |(source_enable_x & source_irq_enable_x))
    || (uv && !uv_q && mode == M_ACTIVE);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_q <= 1'b0;
      irq_pend <= 1'b0;
      interrupt_request_n <= 1'b1;
    end else begin
      uv_q <= (mode == M_SLEEP && !vmin) ? uv_q : uv;
      if (event_now) begin
        irq_pend <= 1'b1;
      end else if (port_w.read_strobe) begin
        irq_pend <= 1'b0;
      end
      interrupt_request_n <= !(irq_pend || event_now);
    end
  end

  // Peripheral enables; transceiver and switch unit inhibited under undervoltage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      transceiver_en <= 1'b0;
      switch_unit_en <= 1'b0;
      watchdog_en <= 1'b0;
      low_power <= 1'b0;
      wake_source_bit_hi <= 1'b0;
      wake_source_bit_lo <= 1'b0;
    end else begin
      transceiver_en <= mode == M_ACTIVE && cfg[CFG_LIN_EN] && !uv;
      switch_unit_en <= mode == M_ACTIVE && !uv
        && (cfg[CFG_SRC_CTRL] || scan) && |source_enable_x;
      watchdog_en <= mode == M_ACTIVE && (cfg[CFG_WDOG_DIS] ? 1'b0 :
        (cfg == CFG_RESET ? wd_strap_q : 1'b1));
      low_power <= mode == M_ACTIVE && sel_n && !cfg[CFG_LIN_EN]
        && !cfg[CFG_SRC_CTRL] && !scan && !watchdog_en;
      wake_source_bit_hi <= src[1];
      wake_source_bit_lo <= src[0];
    end
  end

  spi_word_shifter shifter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sel_n(sel_n),
    .sck(spi_sck),
    .mosi(spi_mosi),
    .miso(spi_miso),
    .port_w(port_w.shifter)
  );
endmodule

// >>> tb/wake_seq_sva.sv
`timescale 1ns/1ps
module wake_seq_sva #(
  parameter int MON_N = 40
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic vs_undervoltage,
  input wire logic spi_select_n,
  input wire logic scan_pulse_y,
  input wire logic spi_miso,
  input wire logic interrupt_request_n,
  input wire logic mcu_reset_out_n,
  input wire logic regulator_en,
  input wire logic receiver_en,
  input wire logic transceiver_en,
  input wire logic switch_unit_en,
  input wire logic low_power,
  input wire logic wake_source_bit_hi,
  input wire logic wake_source_bit_lo
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  int rx_cnt;
  // Length of one receiver monitoring burst while asleep
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      rx_cnt <= 0;
    else if (receiver_en && !regulator_en)
      rx_cnt <= rx_cnt + 1;
    else
      rx_cnt <= 0;
  end
  sequence s_uv_held;
    (mcu_reset_out_n && vs_undervoltage) [*6];
  endsequence
  sequence s_src_set;
    ##[0:3] (wake_source_bit_hi || wake_source_bit_lo);
  endsequence
  property p_uv_inhibit;
    s_uv_held |-> !transceiver_en && !switch_unit_en;
  endproperty
  property p_uv_irq;
    $rose(vs_undervoltage) && mcu_reset_out_n |->
      ##[1:6] !interrupt_request_n;
  endproperty
  property p_irq_src;
    $fell(interrupt_request_n) |-> s_src_set;
  endproperty
  property p_rel_after_reg;
    $rose(mcu_reset_out_n) |-> regulator_en && $past(regulator_en, 8);
  endproperty
  property p_quiet_miso;
    !mcu_reset_out_n |-> !spi_miso;
  endproperty
  property p_wake_xcvr_off;
    $rose(regulator_en) |-> !transceiver_en ##1 !transceiver_en;
  endproperty
  property p_sel_lp;
    !spi_select_n [*5] |-> !low_power;
  endproperty
  property p_scan_lp;
    scan_pulse_y [*5] |-> !low_power;
  endproperty
  property p_mon_len;
    rx_cnt <= MON_N + 6;
  endproperty
  a_uv_inhibit: assert property (p_uv_inhibit)
    else $error("undervoltage inhibit missing");
  a_uv_irq: assert property (p_uv_irq)
    else $error("undervoltage interrupt missing");
  a_irq_src: assert property (p_irq_src)
    else $error("interrupt without source");
  a_rel_after_reg: assert property (p_rel_after_reg)
    else $error("reset released before regulator");
  a_quiet_miso: assert property (p_quiet_miso)
    else $error("serial output active in reset");
  a_wake_xcvr_off: assert property (p_wake_xcvr_off)
    else $error("transceiver on at wake");
  a_sel_lp: assert property (p_sel_lp)
    else $error("low power with select low");
  a_scan_lp: assert property (p_scan_lp)
    else $error("low power with scan high");
  a_mon_len: assert property (p_mon_len)
    else $error("receiver on too long");
endmodule
bind wake_power_seq wake_seq_sva #(.MON_N(MON_N)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .vs_undervoltage(vs_undervoltage),
  .spi_select_n(spi_select_n), .scan_pulse_y(scan_pulse_y),
  .spi_miso(spi_miso), .interrupt_request_n(interrupt_request_n),
  .mcu_reset_out_n(mcu_reset_out_n), .regulator_en(regulator_en),
  .receiver_en(receiver_en), .transceiver_en(transceiver_en),
  .switch_unit_en(switch_unit_en), .low_power(low_power),
  .wake_source_bit_hi(wake_source_bit_hi),
  .wake_source_bit_lo(wake_source_bit_lo));

// >>> tb/spi_host.sv
`timescale 1ns/1ps
module spi_host (
  input wire logic ref_clk,
  output logic spi_select_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic [15:0] rx_word,
  output int rx_count
);
  // Config writes: transceiver, watchdog, sleep
  initial begin
    spi_select_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    rx_word = 16'h0;
    rx_count = 0;
  end
  task automatic half;
    repeat (4) @(posedge ref_clk);
    #2;
  endtask
  // Mode 0, MSB first, n clocks
  task automatic xfer(input logic [15:0] tx, input int n);
    logic [15:0] rx;
    rx = 16'h0;
    spi_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_mosi = tx[15-i];
      half();
      spi_sck = 1'b1;
      rx[15-i] = spi_miso;
      half();
      spi_sck = 1'b0;
    end
    half();
    spi_select_n = 1'b1;
    spi_mosi = ~spi_mosi;
    rx_word = rx;
    rx_count++;
    half();
    half();
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import wake_pkg::*;
  localparam int MON = 40;
  typedef struct {logic [3:0] m; logic [3:0] e;} note_s;
  logic ref_clk, rst_n, bus_below_prewake, bus_dominant;
  logic ignition_wake_input, supply_valid, vs_undervoltage, wdog_strap;
  logic spi_select_n, spi_sck, spi_mosi, spi_miso, scan_pulse_y;
  logic [7:0] source_enable_x, source_irq_enable_x;
  logic interrupt_request_n, mcu_reset_out_n, regulator_en;
  logic termination_en, receiver_en, transceiver_en;
  logic vs_below_min, switch_change, switch_unit_en, watchdog_en, low_power;
  logic wake_source_bit_hi, wake_source_bit_lo;
  logic [15:0] rx_word;
  int rx_count, mismatches, checks_done;
  note_s notes[$];
  wake_power_seq #(.BUS_WAKE_N(8), .MON_N(MON), .IGN_DEB_N(8),
    .STARTUP_N(20), .RESET_N(20)) DUT (.ref_clk, .rst_n,
    .bus_below_prewake, .bus_dominant, .ignition_wake_input,
    .supply_valid, .vs_undervoltage, .vs_below_min, .wdog_strap,
    .spi_select_n, .spi_sck, .spi_mosi, .scan_pulse_y,
    .switch_change, .source_enable_x, .source_irq_enable_x,
    .spi_miso, .interrupt_request_n, .mcu_reset_out_n, .regulator_en,
    .termination_en, .receiver_en, .transceiver_en, .switch_unit_en,
    .watchdog_en, .low_power, .wake_source_bit_hi, .wake_source_bit_lo);
  spi_host host (.ref_clk, .spi_select_n, .spi_sck, .spi_mosi,
    .spi_miso, .rx_word, .rx_count);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic check(input string s, input logic [3:0] v, e);
    checks_done++;
    if (v !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic xfer(input logic [15:0] tx, input logic [3:0] m, e,
      input int n);
    notes.push_back('{m, e});
    host.xfer(tx, n);
  endtask
  task automatic wait_up;
    int i;
    i = 0;
    while (mcu_reset_out_n !== 1'b1 && i < 400) begin
      tick(1);
      i++;
    end
    check("reset_out", {3'h0, mcu_reset_out_n}, 4'h1);
    tick(4);
  endtask
  task automatic stop_test;
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(rx_count) begin
    note_s n;
    if (notes.size() > 0) begin
      n = notes.pop_front();
      check("status", rx_word[15:12] & n.m, n.e);
    end
  end
  initial begin
    #(25ns * 20000);
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(64));
    {rst_n, bus_below_prewake, bus_dominant} = 3'h0;
    {ignition_wake_input, vs_undervoltage, scan_pulse_y} = 3'h0;
    {vs_below_min, switch_change} = 2'h0;
    supply_valid = 1'b1;
    wdog_strap = 1'($urandom);
    source_enable_x = 8'($urandom);
    source_irq_enable_x = 8'($urandom);
    tick(8);
    rst_n = 1'b1;
    tick(8);
    check("early", {3'h0, mcu_reset_out_n}, 4'h0);
    wait_up();
    check("pwr", {regulator_en, transceiver_en, watchdog_en, 1'b0},
      {2'h2, wdog_strap, 1'b0});
    scan_pulse_y = 1'b1;
    tick(6);
    check("scan", {2'h0, switch_unit_en, low_power},
      {2'h0, |source_enable_x, 1'b0});
    scan_pulse_y = 1'b0;
    xfer(16'h1000, 4'hd, 4'h0, 16);
    xfer(16'h1000, 4'h1, 4'h1, 16);
    check("lin", {3'h0, transceiver_en}, 4'h1);
    xfer(16'h1800, 4'h1, 4'h1, 15);
    check("short", {3'h0, regulator_en}, 4'h1);
    vs_undervoltage = 1'b1;
    tick(10);
    check("uv", {interrupt_request_n, transceiver_en, 2'h0}, 4'h0);
    vs_undervoltage = 1'b0;
    tick(10);
    check("uv_end", {3'h0, transceiver_en}, 4'h1);
    xfer(16'h0800, 4'hc, 4'h4, 16);
    check("sleep", {regulator_en, mcu_reset_out_n, 2'h0}, 4'h0);
    ignition_wake_input = 1'b1;
    tick(4);
    ignition_wake_input = 1'b0;
    tick(20);
    check("ign_short", {3'h0, regulator_en}, 4'h0);
    bus_below_prewake = 1'b1;
    tick(10);
    check("mon_on", {3'h0, receiver_en}, 4'h1);
    tick(MON + 10);
    check("float", {regulator_en, receiver_en, 2'h0}, 4'h0);
    bus_below_prewake = 1'b0;
    tick(10);
    bus_below_prewake = 1'b1;
    tick(4);
    bus_dominant = 1'b1;
    tick(14);
    {bus_dominant, bus_below_prewake} = 2'h0;
    tick(6);
    check("bus_wake", {interrupt_request_n, regulator_en, termination_en,
      transceiver_en}, 4'h6);
    check("src_bus", {2'h0, wake_source_bit_hi, wake_source_bit_lo},
      4'h3);
    wait_up();
    xfer(16'h1000, 4'hc, 4'hc, 16);
    check("irq_clr", {3'h0, interrupt_request_n}, 4'h1);
    xfer(16'h0800, 4'hd, 4'h1, 16);
    ignition_wake_input = 1'b1;
    tick(16);
    wait_up();
    xfer(16'h0000, 4'hc, 4'h8, 16);
    ignition_wake_input = 1'b0;
    tick(20);
    xfer(16'h0200, 4'hd, 4'h0, 16);
    check("lp", {2'h0, watchdog_en, low_power}, 4'h1);
    switch_change = 1'b1;
    tick(6);
    switch_change = 1'b0;
    check("sw_src", {2'h0, wake_source_bit_hi, wake_source_bit_lo},
      4'h1);
    check("sw_irq", {3'h0, interrupt_request_n},
      {3'h0, ~|(source_enable_x & source_irq_enable_x)});
    xfer(16'h0800, 4'hd, 4'h4, 16);
    vs_undervoltage = 1'b1;
    tick(10);
    check("uv_sleep", {3'h0, regulator_en}, 4'h0);
    vs_undervoltage = 1'b0;
    {bus_below_prewake, bus_dominant} = 2'h3;
    tick(MON + 20);
    check("stuck", {3'h0, regulator_en}, 4'h0);
    {bus_below_prewake, bus_dominant} = 2'h0;
    tick(8);
    check("stuck_rel", {3'h0, regulator_en}, 4'h1);
    wait_up();
    stop_test();
  end
endmodule
